// File: gtc_assertions.sv
// Port-level assertions for the general timer.
`timescale 1ns/10ps
module gtc_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic [1:0] capturePin,
    input wire logic [1:0] pwmOut
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // =====
    // Setup, one wait state, answer
    sequence setup_s;
        psel && !penable && !pready;
    endsequence
    sequence answer_s;
        !pready ##1 pready;
    endsequence
    chk_one_wait: assert property (setup_s |=> answer_s)
        else $error("late answer");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("long ready");
    chk_err_valid: assert property (pslverr |-> pready)
        else $error("lone error");
    chk_data_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("stale data");
    chk_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("data on write");
    chk_unmapped_err: assert property (setup_s and paddr == 8'h40 |-> ##2 pready && pslverr)
        else $error("no error");
    chk_mapped_ok: assert property (setup_s and paddr == gtc_pkg::OFS_CONTROL |-> ##2 !pslverr)
        else $error("false error");
    // Quiet after reset: PWM outputs low, no ready
    chk_reset_out: assert property ($rose(arst_n) |-> pwmOut == 2'h0 && !pready)
        else $error("reset outputs");
endmodule

// File: gtc_pkg.sv
// Timer register map, fields, reset values and state types.
package gtc_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_WIDTH_CONFIG = 8'h00;
    localparam logic [7:0] OFS_MODE_A = 8'h04;
    localparam logic [7:0] OFS_MODE_B = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h18;
    localparam logic [7:0] OFS_RAW_STATUS = 8'h1c;
    localparam logic [7:0] OFS_MASKED_STATUS = 8'h20;
    localparam logic [7:0] OFS_EVENT_CLEAR = 8'h24;
    localparam logic [7:0] OFS_LOAD_A = 8'h28;
    localparam logic [7:0] OFS_LOAD_B = 8'h2c;
    localparam logic [7:0] OFS_MATCH_A = 8'h30;
    localparam logic [7:0] OFS_MATCH_B = 8'h34;
    localparam logic [7:0] OFS_PRESCALE_A = 8'h38;
    localparam logic [7:0] OFS_PRESCALE_B = 8'h3c;
    localparam logic [7:0] OFS_COUNT_A = 8'h48;
    localparam logic [7:0] OFS_COUNT_B = 8'h4c;

    // ==========================================================
    // Field positions
    localparam int HALF_FIELD_STRIDE = 8;   // Timer B fields sit 8 bits above timer A
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_EVENT_LSB = 2;
    localparam int CTL_PWM_LEVEL_BIT = 6;
    localparam int ST_TIMEOUT_BIT = 0;
    localparam int ST_MATCH_BIT = 1;
    localparam int ST_CAPTURE_BIT = 2;
    localparam int ST_CLOCK_BIT = 3;

    // ==========================================================
    // Encodings
    localparam logic [2:0] CFG_WIDE = 3'h0;
    localparam logic [2:0] CFG_CLOCK = 3'h1;
    localparam logic [2:0] CFG_SPLIT = 3'h4;
    localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;
    localparam logic [1:0] MODE_CAPTURE = 2'h3;
    localparam logic [1:0] EVENT_RISE = 2'h0;
    localparam logic [1:0] EVENT_FALL = 2'h1;
    localparam logic [1:0] EVENT_BOTH = 2'h3;

    // ==========================================================
    // Reset values and timing counts
    localparam logic [15:0] LOAD_RST = 16'hffff;
    localparam logic [15:0] MATCH_RST = 16'hffff;
    localparam logic [15:0] COUNT_RST = 16'hffff;
    localparam logic [31:0] CLOCK_START = 32'h0000_0001;
    localparam logic [14:0] CLOCK_DIV_LAST = 15'h7fff;  // 32768 rising pin edges per second

    // ==========================================================
    // State carriers
    typedef struct packed {
        logic alternateModeSel;
        logic captureModeSel;
        logic [1:0] halfModeField;
    } gtc_mode_t;

    typedef struct packed {
        logic pwmOutputLevel;
        logic [1:0] eventSel;
        logic halfEnable;
    } gtc_ctl_t;

    typedef struct packed {
        gtc_mode_t mode;
        gtc_ctl_t ctl;
        logic [15:0] loadValue;
        logic [15:0] matchValue;
        logic [15:0] countValue;
        logic [15:0] captureValue;
        logic [7:0] prescale;
        logic [7:0] preCount;
        logic [2:0] pinSync;
        logic pwmLevel;
        logic pwmPin;
        logic [3:0] rawFlag;
        logic [3:0] maskBit;
    } gtc_half_t;

    typedef struct packed {
        gtc_half_t [1:0] half;
        logic [2:0] widthConfig;
        logic [14:0] clockDiv;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } gtc_state_t;

endpackage

// File: gtc_pulse_src.sv
// Pulse source model that drives one capture pin.
`timescale 1ns/10ps
module gtc_pulse_src (
    // Clock
    input wire logic clk_sys,
    // Pin toward the timer
    output logic pin
);
    initial pin = 1'b0;
    // Pulses; holds under two clocks raised to two
    task automatic pulse(input int n, input int hold);
        repeat (n) begin
            pin <= 1'b1;
            repeat (hold < 2 ? 2 : hold) @(posedge clk_sys);
            pin <= 1'b0;
            repeat (hold < 2 ? 2 : hold) @(posedge clk_sys);
        end
    endtask
endmodule

// File: gtc_timer.sv
// General timer with two 16-bit halves: count, capture, PWM, 32-bit and clock modes.
//
// Contract
// [R1] Input level held two clocks after edges
// [R2] Prescaler bypassed in capture and PWM modes
// [R3] Capture select low gives down edge counter
// [R4] Load minus match equals edges to count
// [R5] Each qualifying edge decrements until match
// [R6] Count match sets raw and masked flags
// [R7] On match reload and clear enable
// [R8] Edges ignored until enable set again
// [R9] Edge time: free-running count, one edge kind
// [R10] Selected edge captures count, held until next
// [R11] Capture sets raw and masked event flags
// [R12] Edge time keeps counting, reloads at zero
// [R13] PWM entered by alternate, capture, mode two; the code enters PWM only with capture select low
// [R14] PWM counts to zero, reloads, repeats
// [R15] No status flags while in PWM mode
// [R16] PWM high at load, low at match
// [R17] Output level bit inverts PWM polarity
// [R18] Config zero plus mode one or two
// [R19] Config four splits into two halves
// [R20] Clock mode needs 32.768 kHz pin input
// [R21] Clock mode wraps to zero at match
// [R22] Disable before changing any configuration
// [R23] Writing one to clear bit clears flag
// [R24] Capture pins synchronised, edges from samples
//
// Our own choices: the address map and the APB register port.

`timescale 1ns/10ps

module gtc_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Capture/compare pins, index 0 is timer A
    input wire logic [1:0] capturePin,
    output logic [1:0] pwmOut
);

    gtc_pkg::gtc_state_t st;
    gtc_pkg::gtc_state_t next_st;

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic access;
        logic commit;
        logic hit;
        logic [31:0] rdata;
        logic [31:0] wide;
        logic [31:0] clearBits;
        logic [3:0] setFlag [2];
        logic rise;
        logic fall;
        logic countEdge;
        logic timeEdge;
        logic [15:0] dec;
        logic [1:0] ev;
        access = 1'b0;
        commit = 1'b0;
        hit = 1'b0;
        rdata = 32'h0000_0000;
        wide = 32'h0000_0000;
        clearBits = 32'h0000_0000;
        setFlag[0] = 4'h0;
        setFlag[1] = 4'h0;
        rise = 1'b0;
        fall = 1'b0;
        countEdge = 1'b0;
        timeEdge = 1'b0;
        dec = 16'h0000;
        ev = 2'h0;
        next_st = st;

        // One wait state, answer registered
        access = psel && penable;
        commit = access && st.pready;
        next_st.pready = access && !st.pready;
        unique case (paddr)
            gtc_pkg::OFS_WIDTH_CONFIG: begin
                hit = 1'b1;
                rdata = {29'h0, st.widthConfig};
            end
            gtc_pkg::OFS_MODE_A: begin
                hit = 1'b1;
                rdata = {28'h0, st.half[0].mode};
            end
            gtc_pkg::OFS_MODE_B: begin
                hit = 1'b1;
                rdata = {28'h0, st.half[1].mode};
            end
            gtc_pkg::OFS_CONTROL: begin
                hit = 1'b1;
                for (int n = 0; n < 2; n++) begin
                    rdata[n*gtc_pkg::HALF_FIELD_STRIDE + gtc_pkg::CTL_ENABLE_BIT] =
                        st.half[n].ctl.halfEnable;
                    rdata[n*gtc_pkg::HALF_FIELD_STRIDE + gtc_pkg::CTL_EVENT_LSB +: 2] =
                        st.half[n].ctl.eventSel;
                    rdata[n*gtc_pkg::HALF_FIELD_STRIDE + gtc_pkg::CTL_PWM_LEVEL_BIT] =
                        st.half[n].ctl.pwmOutputLevel;
                end
            end
            gtc_pkg::OFS_EVENT_MASK: begin
                hit = 1'b1;
                rdata = {16'h0, 4'h0, st.half[1].maskBit, 4'h0, st.half[0].maskBit};
            end
            gtc_pkg::OFS_RAW_STATUS: begin
                hit = 1'b1;
                rdata = {16'h0, 4'h0, st.half[1].rawFlag, 4'h0, st.half[0].rawFlag};
            end
            gtc_pkg::OFS_MASKED_STATUS: begin
                hit = 1'b1;
                rdata = {16'h0, 4'h0, st.half[1].rawFlag & st.half[1].maskBit,
                         4'h0, st.half[0].rawFlag & st.half[0].maskBit};
            end
            gtc_pkg::OFS_EVENT_CLEAR: hit = 1'b1;  // Write-only, reads zero
            gtc_pkg::OFS_LOAD_A: begin
                hit = 1'b1;
                rdata = (st.widthConfig == gtc_pkg::CFG_SPLIT) ? {16'h0, st.half[0].loadValue}
                        : {st.half[1].loadValue, st.half[0].loadValue};
            end
            gtc_pkg::OFS_LOAD_B: begin
                hit = 1'b1;
                rdata = {16'h0, st.half[1].loadValue};
            end
            gtc_pkg::OFS_MATCH_A: begin
                hit = 1'b1;
                rdata = (st.widthConfig == gtc_pkg::CFG_SPLIT) ? {16'h0, st.half[0].matchValue}
                        : {st.half[1].matchValue, st.half[0].matchValue};
            end
            gtc_pkg::OFS_MATCH_B: begin
                hit = 1'b1;
                rdata = {16'h0, st.half[1].matchValue};
            end
            gtc_pkg::OFS_PRESCALE_A: begin
                hit = 1'b1;
                rdata = {24'h0, st.half[0].prescale};
            end
            gtc_pkg::OFS_PRESCALE_B: begin
                hit = 1'b1;
                rdata = {24'h0, st.half[1].prescale};
            end
            gtc_pkg::OFS_COUNT_A, gtc_pkg::OFS_COUNT_B: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        // Count reads show capture in edge time
        for (int n = 0; n < 2; n++) begin
            if (paddr == (n == 0 ? gtc_pkg::OFS_COUNT_A : gtc_pkg::OFS_COUNT_B)) begin
                if (st.widthConfig != gtc_pkg::CFG_SPLIT && n == 0) begin
                    rdata = {st.half[1].countValue, st.half[0].countValue};
                end else if (st.half[n].mode.halfModeField == gtc_pkg::MODE_CAPTURE &&
                             st.half[n].mode.captureModeSel) begin
                    rdata = {16'h0, st.half[n].captureValue};  // [R10]
                end else begin
                    rdata = {16'h0, st.half[n].countValue};
                end
            end
        end
        next_st.prdata = (access && !st.pready && !pwrite) ? rdata : 32'h0000_0000;
        next_st.pslverr = access && !st.pready && !hit;

        // Synchronisers; edges from stages two and three
        for (int n = 0; n < 2; n++) begin
            next_st.half[n].pinSync = {st.half[n].pinSync[1:0], capturePin[n]};  // [R24]
        end

        // Split: halves run alone
        if (st.widthConfig == gtc_pkg::CFG_SPLIT) begin  // [R19]
            for (int n = 0; n < 2; n++) begin
                rise = st.half[n].pinSync[1] && !st.half[n].pinSync[2];  // [R24] [R1]
                fall = !st.half[n].pinSync[1] && st.half[n].pinSync[2];
                ev = st.half[n].ctl.eventSel;
                dec = st.half[n].countValue - 16'h0001;
                if (st.half[n].ctl.halfEnable) begin
                    if (st.half[n].mode.alternateModeSel) begin
                        // PWM: no prescaler, no flags  [R13] [R2] [R15]
                        if (st.half[n].mode.halfModeField == gtc_pkg::MODE_PERIODIC &&
                            !st.half[n].mode.captureModeSel) begin
                            next_st.half[n].countValue = (st.half[n].countValue == 16'h0000)
                                ? st.half[n].loadValue : dec;  // [R14]
                            if (st.half[n].countValue == st.half[n].loadValue) begin
                                next_st.half[n].pwmLevel = 1'b1;  // [R16]
                            end else if (st.half[n].countValue == st.half[n].matchValue) begin
                                next_st.half[n].pwmLevel = 1'b0;  // [R16]
                            end
                        end
                    end else if (st.half[n].mode.halfModeField == gtc_pkg::MODE_CAPTURE) begin
                        if (!st.half[n].mode.captureModeSel) begin
                            // Edge count: disabled on match, so later edges fall away  [R8]
                            countEdge = (rise && ev != gtc_pkg::EVENT_FALL) ||
                                        (fall && (ev == gtc_pkg::EVENT_FALL ||
                                                  ev == gtc_pkg::EVENT_BOTH));  // [R3]
                            if (countEdge) begin
                                if (dec == st.half[n].matchValue) begin  // [R4]
                                    setFlag[n][gtc_pkg::ST_MATCH_BIT] = 1'b1;  // [R6]
                                    next_st.half[n].countValue = st.half[n].loadValue;  // [R7]
                                    next_st.half[n].ctl.halfEnable = 1'b0;  // [R7]
                                end else begin
                                    next_st.half[n].countValue = dec;  // [R5]
                                end
                            end
                        end else begin
                            // Edge time: both-edge select falls back to rising  [R9]
                            timeEdge = (ev == gtc_pkg::EVENT_FALL) ? fall : rise;
                            next_st.half[n].countValue = (st.half[n].countValue == 16'h0000)
                                ? st.half[n].loadValue : dec;  // [R12]
                            if (timeEdge) begin
                                next_st.half[n].captureValue = st.half[n].countValue;  // [R10]
                                setFlag[n][gtc_pkg::ST_CAPTURE_BIT] = 1'b1;  // [R11]
                            end
                        end
                    end else if (st.half[n].mode.halfModeField == gtc_pkg::MODE_ONE_SHOT ||
                                 st.half[n].mode.halfModeField == gtc_pkg::MODE_PERIODIC) begin
                        // One-shot or periodic, prescaled
                        if (st.half[n].countValue == 16'h0000) begin
                            next_st.half[n].countValue = st.half[n].loadValue;
                            next_st.half[n].preCount = st.half[n].prescale;
                            setFlag[n][gtc_pkg::ST_TIMEOUT_BIT] = 1'b1;
                            if (st.half[n].mode.halfModeField == gtc_pkg::MODE_ONE_SHOT) begin
                                next_st.half[n].ctl.halfEnable = 1'b0;
                            end
                        end else if (st.half[n].preCount == 8'h00) begin
                            next_st.half[n].preCount = st.half[n].prescale;
                            next_st.half[n].countValue = dec;
                        end else begin
                            next_st.half[n].preCount = st.half[n].preCount - 8'h01;
                        end
                    end
                end
                next_st.half[n].pwmPin =
                    next_st.half[n].pwmLevel ^ st.half[n].ctl.pwmOutputLevel;  // [R17]
            end
        end else if (st.half[0].ctl.halfEnable) begin
            wide = {st.half[1].countValue, st.half[0].countValue};
            if (st.widthConfig == gtc_pkg::CFG_WIDE &&
                (st.half[0].mode.halfModeField == gtc_pkg::MODE_ONE_SHOT ||
                 st.half[0].mode.halfModeField == gtc_pkg::MODE_PERIODIC)) begin  // [R18]
                if (wide == 32'h0000_0000) begin
                    wide = {st.half[1].loadValue, st.half[0].loadValue};
                    setFlag[0][gtc_pkg::ST_TIMEOUT_BIT] = 1'b1;
                    if (st.half[0].mode.halfModeField == gtc_pkg::MODE_ONE_SHOT) begin
                        next_st.half[0].ctl.halfEnable = 1'b0;  // [R18]
                    end
                end else begin
                    wide = wide - 32'h0000_0001;
                end
            end else if (st.widthConfig == gtc_pkg::CFG_CLOCK) begin
                // Pin A slow reference divided to seconds  [R20]
                if (st.half[0].pinSync[1] && !st.half[0].pinSync[2]) begin
                    if (st.clockDiv == gtc_pkg::CLOCK_DIV_LAST) begin
                        next_st.clockDiv = 15'h0000;
                        if (wide == {st.half[1].matchValue, st.half[0].matchValue}) begin
                            wide = 32'h0000_0000;  // [R21]
                            setFlag[0][gtc_pkg::ST_CLOCK_BIT] = 1'b1;
                        end else begin
                            wide = wide + 32'h0000_0001;
                        end
                    end else begin
                        next_st.clockDiv = st.clockDiv + 15'h0001;
                    end
                end
            end
            next_st.half[1].countValue = wide[31:16];
            next_st.half[0].countValue = wide[15:0];
        end

        // Writes land at the answer edge
        if (commit && pwrite && !st.pslverr) begin
            unique case (paddr)
                gtc_pkg::OFS_WIDTH_CONFIG: begin
                    next_st.widthConfig = pwdata[2:0];
                    if (pwdata[2:0] == gtc_pkg::CFG_CLOCK) begin
                        next_st.half[1].countValue = gtc_pkg::CLOCK_START[31:16];
                        next_st.half[0].countValue = gtc_pkg::CLOCK_START[15:0];
                        next_st.clockDiv = 15'h0000;
                    end
                end
                gtc_pkg::OFS_MODE_A: next_st.half[0].mode = pwdata[3:0];
                gtc_pkg::OFS_MODE_B: next_st.half[1].mode = pwdata[3:0];
                gtc_pkg::OFS_CONTROL: begin
                    for (int n = 0; n < 2; n++) begin
                        next_st.half[n].ctl.halfEnable =
                            pwdata[n*gtc_pkg::HALF_FIELD_STRIDE + gtc_pkg::CTL_ENABLE_BIT];
                        next_st.half[n].ctl.eventSel =
                            pwdata[n*gtc_pkg::HALF_FIELD_STRIDE + gtc_pkg::CTL_EVENT_LSB +: 2];
                        next_st.half[n].ctl.pwmOutputLevel =
                            pwdata[n*gtc_pkg::HALF_FIELD_STRIDE + gtc_pkg::CTL_PWM_LEVEL_BIT];
                    end
                end
                gtc_pkg::OFS_EVENT_MASK: begin
                    next_st.half[0].maskBit = pwdata[3:0];
                    next_st.half[1].maskBit = pwdata[11:8];
                end
                gtc_pkg::OFS_EVENT_CLEAR: clearBits = pwdata;  // [R23]
                gtc_pkg::OFS_LOAD_A: begin
                    next_st.half[0].loadValue = pwdata[15:0];
                    next_st.half[0].countValue = pwdata[15:0];  // [R9]
                    if (st.widthConfig != gtc_pkg::CFG_SPLIT) begin
                        next_st.half[1].loadValue = pwdata[31:16];
                        next_st.half[1].countValue = pwdata[31:16];
                    end
                end
                gtc_pkg::OFS_LOAD_B: begin
                    next_st.half[1].loadValue = pwdata[15:0];
                    next_st.half[1].countValue = pwdata[15:0];  // [R9]
                end
                gtc_pkg::OFS_MATCH_A: begin
                    next_st.half[0].matchValue = pwdata[15:0];
                    if (st.widthConfig != gtc_pkg::CFG_SPLIT) begin
                        next_st.half[1].matchValue = pwdata[31:16];
                    end
                end
                gtc_pkg::OFS_MATCH_B: next_st.half[1].matchValue = pwdata[15:0];
                gtc_pkg::OFS_PRESCALE_A: next_st.half[0].prescale = pwdata[7:0];
                gtc_pkg::OFS_PRESCALE_B: next_st.half[1].prescale = pwdata[7:0];
                default: clearBits = 32'h0000_0000;  // Count registers are read-only
            endcase
        end

        // Sticky flags; same-cycle set beats clear
        for (int n = 0; n < 2; n++) begin
            next_st.half[n].rawFlag = (st.half[n].rawFlag &
                ~clearBits[n*gtc_pkg::HALF_FIELD_STRIDE +: 4]) | setFlag[n];  // [R23]
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            for (int n = 0; n < 2; n++) begin
                st.half[n].loadValue <= gtc_pkg::LOAD_RST;
                st.half[n].matchValue <= gtc_pkg::MATCH_RST;
                st.half[n].countValue <= gtc_pkg::COUNT_RST;  // [R9]
            end
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs from the state register
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign pwmOut = {st.half[1].pwmPin, st.half[0].pwmPin};

endmodule

// File: tb_top.sv
// Self-checking testbench for the general timer.
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} gtc_row_t;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat, snap;
    logic pready, pslverr, rerr;
    logic [1:0] capturePin, pwmOut;
    int fails = 0;
    int cmp_count = 0;
    int hi;
    logic [1:0] ev [3] = '{2'h0, 2'h1, 2'h3};
    logic [31:0] cntExp [3] = '{32'h9, 32'h8, 32'ha};
    // Reset values; 0x40 unmapped
    gtc_row_t rows [10] = '{'{8'h00, 0, 0}, '{8'h0c, 0, 0}, '{8'h18, 0, 0},
        '{8'h1c, 0, 0}, '{8'h28, 32'hffffffff, 0}, '{8'h2c, 32'hffff, 0},
        '{8'h30, 32'hffffffff, 0}, '{8'h38, 0, 0}, '{8'h48, 32'hffffffff, 0},
        '{8'h40, 0, 1}};
    always #12.5 clk_sys = ~clk_sys;
    gtc_timer dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capturePin(capturePin), .pwmOut(pwmOut));
    gtc_pulse_src src_a (.clk_sys(clk_sys), .pin(capturePin[0]));
    gtc_pulse_src src_b (.clk_sys(clk_sys), .pin(capturePin[1]));
    // =====
    // Compare and bus tasks
    task automatic check(input string w, input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            fails++;
            $display("Error %s expected %h seen %h", w, x, s);
        end
    endtask
    // Held until ready; one idle edge after
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
        if (n >= 50) fails++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string w, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(w, rdat, x);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        end_sim;
    end
    // =====
    // Reset table, edge count, edge time, PWM
    initial begin
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[i]) begin
            rd("reset value", rows[i].a, rows[i].d);
            check("slave error", {31'h0, rerr}, {31'h0, rows[i].e});
        end
        $display("test reset done");
        wr(gtc_pkg::OFS_WIDTH_CONFIG, 32'h4);
        wr(gtc_pkg::OFS_MODE_A, 32'h3);
        wr(gtc_pkg::OFS_LOAD_A, 32'ha);
        wr(gtc_pkg::OFS_MATCH_A, 32'h6);
        wr(gtc_pkg::OFS_EVENT_MASK, 32'h2);
        wr(gtc_pkg::OFS_CONTROL, 32'hd);
        src_a.pulse(1, 2);
        repeat (6) @(posedge clk_sys);
        rd("edge count", gtc_pkg::OFS_COUNT_A, 32'h8);
        src_a.pulse(2, 4);
        repeat (6) @(posedge clk_sys);
        rd("reloaded count", gtc_pkg::OFS_COUNT_A, 32'ha);
        rd("self disable", gtc_pkg::OFS_CONTROL, 32'hc);
        rd("match raw", gtc_pkg::OFS_RAW_STATUS, 32'h2);
        rd("match masked", gtc_pkg::OFS_MASKED_STATUS, 32'h2);
        // Each edge kind, count kept while off
        for (int e = 0; e < 3; e++) begin
            wr(gtc_pkg::OFS_CONTROL, {28'h0, ev[e], 2'h1});
            src_a.pulse(1, 3);
            repeat (6) @(posedge clk_sys);
            rd("edge kind", gtc_pkg::OFS_COUNT_A, cntExp[e]);
            wr(gtc_pkg::OFS_CONTROL, {28'h0, ev[e], 2'h0});
        end
        wr(gtc_pkg::OFS_EVENT_CLEAR, 32'hf0f);
        rd("flags cleared", gtc_pkg::OFS_RAW_STATUS, 32'h0);
        $display("test edge count done");
        wr(gtc_pkg::OFS_MODE_B, 32'h7);
        wr(gtc_pkg::OFS_LOAD_B, 32'h40);
        wr(gtc_pkg::OFS_EVENT_MASK, 32'h400);
        wr(gtc_pkg::OFS_CONTROL, 32'h100);
        for (int k = 0; k < 2; k++) begin
            src_b.pulse(1, 8);
            repeat (6) @(posedge clk_sys);
            apb(1'b0, gtc_pkg::OFS_COUNT_B, 32'h0);
            snap = rdat;
            check("capture range", {31'h0, snap <= 32'h40}, 32'h1);
            repeat (70) @(posedge clk_sys);
            rd("capture held", gtc_pkg::OFS_COUNT_B, snap);
        end
        rd("capture raw", gtc_pkg::OFS_RAW_STATUS, 32'h400);
        rd("capture masked", gtc_pkg::OFS_MASKED_STATUS, 32'h400);
        wr(gtc_pkg::OFS_CONTROL, 32'h0);
        wr(gtc_pkg::OFS_EVENT_CLEAR, 32'hf0f);
        $display("test edge time done");
        // Period ten, high 3 of 10
        wr(gtc_pkg::OFS_MODE_A, 32'ha);
        wr(gtc_pkg::OFS_PRESCALE_A, 32'h3);
        wr(gtc_pkg::OFS_LOAD_A, 32'h9);
        wr(gtc_pkg::OFS_MATCH_A, 32'h6);
        for (int p = 0; p < 2; p++) begin
            wr(gtc_pkg::OFS_CONTROL, p ? 32'h41 : 32'h1);
            repeat (20) @(posedge clk_sys);
            hi = 0;
            repeat (100) begin
                @(posedge clk_sys);
                hi += int'(pwmOut[0]);
            end
            check("pwm high", 32'(hi), p ? 32'd70 : 32'd30);
            wr(gtc_pkg::OFS_CONTROL, 32'h0);
        end
        rd("pwm no flags", gtc_pkg::OFS_RAW_STATUS, 32'h0);
        $display("test pwm done");
        end_sim;
    end
endmodule
bind gtc_timer gtc_assertions chk_u (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capturePin(capturePin), .pwmOut(pwmOut));
